//--- sim/converter_model.sv
// Far-side converter model that delivers received alignment parameters.
`default_nettype none
module converter_model #(
  parameter int NUM_LANES = 2
) (
  // Clock.
  input  wire logic                     pclk,
  // Captured parameter words, eight per lane.
  output logic [NUM_LANES-1:0]          cap_valid,
  output logic [NUM_LANES*256-1:0]      cap_words
);
  timeunit 1ns;
  timeprecision 1ps;

  // Nothing is offered until the first sequence arrives.
  initial begin
    cap_valid = '0;
    cap_words = '0;
  end

  // One lane's sequence is offered for one cycle, then the words turn over.
  task automatic send(input int l, input logic [255:0] w);
    @(posedge pclk);
    cap_valid[l] <= 1'b1;
    cap_words[l*256+:256] <= w;
    @(posedge pclk);
    cap_valid[l] <= 1'b0;
    cap_words[l*256+:256] <= ~w;
  endtask
endmodule
`default_nettype wire

//--- sim/lane_align_config_registers_tb_top.sv
// Self-checking bench for the lane alignment register bank.
`default_nettype none
module lane_align_config_registers_tb_top;
  import lane_align_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic         pclk, presetn, pwrite, penable, psel_rx, psel_tx;
  logic [11:0]  paddr;
  word_t        pwdata, rd_rx, rd_tx, t3, t4, t5, t6, t7, q;
  logic         rdy_rx, rdy_tx, err_rx, err_tx, e;
  logic [1:0]   cap_valid;
  logic [511:0] cap_words;
  logic [2:0]   rev, sub;
  logic [7:0]   oct;
  logic [4:0]   frm, lns;
  logic         scrambling_enable;
  logic [15:0]  parameter_checksum;
  logic [9:0]   tx_num;
  int           n_mismatch, num_checks;
  int           lid_rx[2], lid_tx[2];
  word_t        cap[2][9];
  word_t        txw[9];
  word_t rxm[9] = '{32'h1f, 32'h707, 32'hff, 32'h1f, 32'h1f1f0fff,
                    32'h031f1fff, 32'h1f011f01, 32'h00ffffff, 32'h0001010f};
  word_t txm[9] = '{32'h1f, 32'h0, 32'h0, 32'h0, 32'hfff, 32'h031f1fff,
                    32'h1f011f00, 32'hffff, 32'h1010f};

  lane_align_config_registers #(.NUM_LANES(2), .IS_RX(1'b1)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel_rx), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(rd_rx),
    .pready(rdy_rx), .pslverr(err_rx), .cap_valid(cap_valid),
    .cap_words(cap_words), .build_link_revision(rev), .build_subclass(sub),
    .build_octets_m1(oct), .build_frames_m1(frm), .build_lanes_m1(lns),
    .build_scrambling_enable(scrambling_enable), .tx_lane_checksum(parameter_checksum),
    .tx_lane_number(), .tx_cfg3_word(), .tx_cfg4_word(), .tx_cfg5_word(),
    .tx_cfg6_word(), .tx_cfg7_word());
  lane_align_config_registers #(.NUM_LANES(2), .IS_RX(1'b0)) u_dut_tx (
    .pclk(pclk), .presetn(presetn), .psel(psel_tx), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(rd_tx),
    .pready(rdy_tx), .pslverr(err_tx), .cap_valid(cap_valid),
    .cap_words(cap_words), .build_link_revision(rev), .build_subclass(sub),
    .build_octets_m1(oct), .build_frames_m1(frm), .build_lanes_m1(lns),
    .build_scrambling_enable(scrambling_enable), .tx_lane_checksum(parameter_checksum),
    .tx_lane_number(tx_num), .tx_cfg3_word(t3), .tx_cfg4_word(t4),
    .tx_cfg5_word(t5), .tx_cfg6_word(t6), .tx_cfg7_word(t7));
  converter_model #(.NUM_LANES(2)) u_conv (
    .pclk(pclk), .cap_valid(cap_valid), .cap_words(cap_words));

  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Expected read value from the bench's own register model.
  function automatic word_t expv(bit tx, int l, int r);
    if (!tx) return (r == 0) ? word_t'(lid_rx[l]) : cap[l][r];
    case (r)
      0: return word_t'(lid_tx[l]);
      1: return {21'h0, rev, 5'h0, sub};
      2: return {24'h0, oct};
      3: return {27'h0, frm};
      4: return {3'h0, lns, 3'h0, 5'(lid_tx[l]), txw[4][15:0]};
      6: return txw[6] | word_t'(scrambling_enable);
      7: return {8'h0, parameter_checksum[l*8+:8], txw[7][15:0]};
      default: return txw[r];
    endcase
  endfunction

  // Counts a comparison and reports a difference at once.
  task automatic chk(string what, word_t x, word_t s);
    num_checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, x, s);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(bit tx, bit wr, logic [11:0] a, word_t d,
                     output word_t rq, output logic re);
    @(posedge pclk);
    psel_rx <= !tx;
    psel_tx <= tx;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while ((tx ? rdy_tx : rdy_rx) !== 1'b1);
    rq = tx ? rd_tx : rd_rx;
    re = tx ? err_tx : err_rx;
    psel_rx <= 1'b0;
    psel_tx <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register write that also updates the model.
  task automatic wr(bit tx, int l, int r, word_t d);
    apb(tx, 1'b1, 12'(l * 64 + r * 4), d, q, e);
    if (r == 0 && tx) lid_tx[l] = d & 32'h1f;
    else if (r == 0) lid_rx[l] = d & 32'h1f;
    else if (tx) txw[r] = d & txm[r];
  endtask

  // Reads every register of both lanes and compares with the model.
  task automatic read_all(bit tx);
    for (int l = 0; l < 2; l++) begin
      for (int r = 0; r < 9; r++) begin
        apb(tx, 1'b0, 12'(l * 64 + r * 4), '0, q, e);
        chk($sformatf("read t%0d l%0d r%0d", tx, l, r), expv(tx, l, r), q);
        chk("read error flag", 32'h0, {31'h0, e});
      end
    end
  endtask

  // Unmapped access: error flagged, nothing stored, zero read.
  task automatic bad(bit tx, logic [11:0] a);
    apb(tx, 1'b1, a, 32'hffff_ffff, q, e);
    chk("error on write", 32'h1, {31'h0, e});
    apb(tx, 1'b0, a, '0, q, e);
    chk("error on read", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
  endtask

  // Converter delivers a random sequence on one lane.
  task automatic capture(int l);
    logic [255:0] w;
    for (int i = 0; i < 8; i++) w[i*32+:32] = $urandom;
    u_conv.send(l, w);
    for (int r = 1; r < 9; r++) cap[l][r] = w[(r-1)*32+:32] & rxm[r];
  endtask

  // Holds reset for ten cycles and returns the model to reset values.
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    lid_rx = '{0, 1};
    lid_tx = '{0, 1};
    cap = '{default: '0};
    txw = '{default: '0};
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    #200us;
    n_mismatch++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    void'($urandom(55539));
    {presetn, pwrite, penable, psel_rx, psel_tx, paddr, pwdata} = '0;
    rev = 3'($urandom_range(0, 1));
    sub = 3'($urandom_range(0, 2));
    oct = 8'($urandom);
    frm = 5'($urandom);
    lns = 5'($urandom);
    scrambling_enable = 1'($urandom);
    parameter_checksum = 16'($urandom);
    do_reset();
    read_all(1'b0);
    read_all(1'b1);
    wr(1'b0, 0, 0, 32'hffff_ffff);
    wr(1'b0, 1, 0, word_t'($urandom_range(0, 30)));
    wr(1'b0, 0, 5, 32'hffff_ffff);
    capture(0);
    capture(1);
    read_all(1'b0);
    capture(1);
    read_all(1'b0);
    bad(1'b0, 12'h080);
    bad(1'b1, 12'h024);
    bad(1'b0, 12'h002);
    for (int r = 1; r < 9; r++) wr(1'b1, r % 2, r, $urandom);
    read_all(1'b1);
    chk("tx cfg4 word", txw[5], t4);
    chk("tx cfg7 word", txw[8], t7);
    chk("tx cfg3 word", txw[4], t3);
    chk("tx cfg5 word", txw[6], t5);
    chk("tx cfg6 word", txw[7], t6);
    wr(1'b1, 0, 0, 32'h3);
    wr(1'b1, 1, 0, 32'h1d);
    apb(1'b1, 1'b0, 12'h040, '0, q, e);
    chk("tx lane_identifier", 32'h1d, q);
    chk("tx lane numbers", {22'h0, 10'h3a3}, {22'h0, tx_num});
    do_reset();
    read_all(1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire

//--- src/lane_align_config_registers.sv
// APB register bank holding per-lane alignment parameters of a link core.
//
// How it works
// - Five-bit lane identifier, resets to lane index.
// - Each lane has its own register copy.
// - Receiver captures each lane's received parameters.
// - Transmitter version, subclass, F, K from build.
// - Transmitter writable fields sent on every lane.
// - Octets per frame, bits 7:0, minus one.
// - Frames per multiframe, bits 4:0, minus one.
// - Lanes per link 28:24, from build in transmitter.
// - Lane number 20:16, captured in receiver, lane identifier in transmitter.
// - Bank number 11:8, device number 7:0.
// - Control bits 25:24, total bits 20:16.
// - Resolution 12:8, converters 7:0, minus one.
// - Control words 28:24, high density bit 16.
// - Samples per converter 12:8, minus one.
// - Scrambling enable bit 0, from build in transmitter.
// - Checksum 23:16, computed per lane in transmitter.
// - Spare bytes at 15:8 and 7:0.
// - Adjust direction bit 16, phase request bit 8.
// - Phase adjust count bits 3:0.
`include "lane_align_regs.svh"
`default_nettype none
module lane_align_config_registers #(
  parameter int NUM_LANES = 8,
  parameter bit IS_RX     = 1'b1
) (
  // Clock and reset.
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave.
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire lane_align_pkg::word_t  pwdata,
  output lane_align_pkg::word_t       prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Receive capture, eight words per lane.
  input  wire logic [NUM_LANES-1:0]   cap_valid,
  input  wire logic [NUM_LANES*256-1:0] cap_words,
  // Transmit build configuration.
  input  wire logic [2:0]             build_link_revision,
  input  wire logic [2:0]             build_subclass,
  input  wire logic [7:0]             build_octets_m1,
  input  wire logic [4:0]             build_frames_m1,
  input  wire logic [4:0]             build_lanes_m1,
  input  wire logic                   build_scrambling_enable,
  input  wire logic [NUM_LANES*8-1:0] tx_lane_checksum,
  // Transmit lane number per lane; parameters applied to all lanes.
  output logic [NUM_LANES*5-1:0]      tx_lane_number,
  output lane_align_pkg::word_t       tx_cfg3_word,
  output lane_align_pkg::word_t       tx_cfg4_word,
  output lane_align_pkg::word_t       tx_cfg5_word,
  output lane_align_pkg::word_t       tx_cfg6_word,
  output lane_align_pkg::word_t       tx_cfg7_word
);
  import lane_align_pkg::*;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------

  // A hit is an aligned word inside a present lane's nine registers.
  function automatic logic addr_hit(input logic [11:0] a);
    logic ok;
    ok = 1'b0;
    if (a[1:0] != 2'b00) ok = 1'b0;
    else if (int'(a[`LANE_SEL_MSB:`LANE_SEL_LSB]) >= NUM_LANES) ok = 1'b0;
    else if (int'(a[`REG_SEL_MSB:`REG_SEL_LSB]) >= `REG_COUNT) ok = 1'b0;
    else ok = 1'b1;
    return ok;
  endfunction

  logic        setup_phase;
  logic        access_phase;
  logic        hit;
  logic [5:0]  sel_lane;
  logic [3:0]  sel_reg;
  logic        wr_access;

  // Decode the request fields once for read and write paths.
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign hit          = addr_hit(paddr);
  assign sel_lane     = paddr[`LANE_SEL_MSB:`LANE_SEL_LSB];
  assign sel_reg      = paddr[`REG_SEL_MSB:`REG_SEL_LSB];
  assign wr_access    = access_phase && pwrite && hit;

  // Zero wait states; an unmapped or misaligned access errors.
  assign pready  = 1'b1;
  assign pslverr = access_phase && !hit;

  // --------------------------------------------------------------------
  // Lane register copies
  // --------------------------------------------------------------------
  logic [4:0]        lane_identifier  [NUM_LANES];
  logic [255:0]      lane_raw [NUM_LANES];
  word_t             view     [NUM_LANES][`REG_COUNT];
  logic [NUM_LANES-1:0] lane_wr;

  generate
    for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
      // A transmitter broadcasts parameter writes so every copy matches;
      // the lane identifier always stays private to its lane.
      assign lane_wr[l] = wr_access &&
        (int'(sel_lane) == l ||
         (!IS_RX && sel_reg != REG_LANE_IDENTIFIER));

      lane_cfg_bank #(
        .LANE_INDEX (l),
        .IS_RX      (IS_RX)
      ) u_bank (
        .pclk      (pclk),
        .presetn   (presetn),
        .wr_en     (lane_wr[l]),
        .wr_index  (sel_reg),
        .wr_data   (pwdata),
        .cap_valid (cap_valid[l]),
        .cap_words (cap_words[l*256 +: 256]),
        .lane_identifier   (lane_identifier[l]),
        .cfg_words (lane_raw[l])
      );

      // Software view; a transmitter shows core-generated fields in place.
      always_comb begin
        view[l][0] = {27'h0, lane_identifier[l]};
        for (int i = 1; i < `REG_COUNT; i++) begin
          view[l][i] = lane_raw[l][(i-1)*32 +: 32];
        end
        if (!IS_RX) begin
          view[l][REG_CFG0] =
            (word_t'(build_link_revision) << `REVISION_LSB) |
            word_t'(build_subclass);
          view[l][REG_CFG1] = word_t'(build_octets_m1);
          view[l][REG_CFG2] = word_t'(build_frames_m1);
          view[l][REG_CFG3] = lane_raw[l][127:96] |
            (word_t'(build_lanes_m1) << `LANES_LSB) |
            (word_t'(lane_identifier[l]) << `LANE_NUMBER_LSB);
          view[l][REG_CFG5] = lane_raw[l][191:160] |
            word_t'(build_scrambling_enable);
          view[l][REG_CFG6] = lane_raw[l][223:192] |
            (word_t'(tx_lane_checksum[l*8 +: 8]) << `CHECKSUM_LSB);
        end
      end

      // Each lane sends its own identifier as its lane number.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_lane_number[l*5 +: 5] <= 5'(l);
        end else begin
          tx_lane_number[l*5 +: 5] <= lane_identifier[l];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Transmit parameter outputs
  // --------------------------------------------------------------------

  // All copies match in a transmitter, so lane 0 drives every lane.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cfg3_word <= `CFG_RESET;
      tx_cfg4_word <= `CFG_RESET;
      tx_cfg5_word <= `CFG_RESET;
      tx_cfg6_word <= `CFG_RESET;
      tx_cfg7_word <= `CFG_RESET;
    end else begin
      tx_cfg3_word <= lane_raw[0][127:96];
      tx_cfg4_word <= lane_raw[0][159:128];
      tx_cfg5_word <= lane_raw[0][191:160];
      tx_cfg6_word <= lane_raw[0][223:192];
      tx_cfg7_word <= lane_raw[0][255:224];
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  word_t next_prdata;

  // Read data is picked in the setup cycle and stands for the access.
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit && !pwrite) begin
      next_prdata = view[int'(sel_lane)][int'(sel_reg)] &
                    field_mask(sel_reg);
    end
  end

  // Register read data so the bus sees a flip-flop output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata <= next_prdata;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence read_setup_s;
    setup_phase && !pwrite && hit;
  endsequence

  sequence read_access_s;
    access_phase && pready;
  endsequence

  reserved_read_zero_a: assert property (
    read_setup_s ##1 read_access_s |->
      (prdata & ~field_mask($past(sel_reg))) == 32'h0000_0000)
    else $error("reserved bits of a read are not zero");

  read_data_timing_a: assert property (
    read_setup_s ##0 (sel_reg == REG_LANE_IDENTIFIER && sel_lane == 6'h00) |=>
      read_access_s |-> prdata == word_t'($past(lane_identifier[0])))
    else $error("read data does not match the addressed register");

  unmapped_error_a: assert property (
    access_phase && !hit |-> pslverr && pready &&
      prdata == 32'h0000_0000)
    else $error("unmapped access did not error");

  lane_identifier_write_a: assert property (
    wr_access && sel_reg == REG_LANE_IDENTIFIER && sel_lane == 6'h00 |=>
      lane_identifier[0] == $past(pwdata[4:0]))
    else $error("lane identifier write not stored");

  rx_capture_a: assert property (
    IS_RX && cap_valid[0] |=>
      lane_raw[0][39:32] == $past(cap_words[39:32]) &&
      lane_raw[0][63:40] == 24'h00_0000)
    else $error("octets per frame not captured");

  tx_broadcast_a: assert property (
    !IS_RX && wr_access && sel_reg == REG_CFG4 |=>
      lane_raw[NUM_LANES-1][159:128] == lane_raw[0][159:128] ##1
      tx_cfg4_word == lane_raw[0][159:128])
    else $error("transmit parameter not applied to all lanes");

  tx_generated_a: assert property (
    !IS_RX |-> view[0][REG_CFG1] == word_t'(build_octets_m1) &&
      view[0][REG_CFG0][10:8] == build_link_revision)
    else $error("generated transmit fields not shown");

  tx_readonly_a: assert property (
    !IS_RX |-> lane_raw[0][127:112] == 16'h0000 &&
      lane_raw[0][160] == 1'b0 && lane_raw[0][215:208] == 8'h00)
    else $error("generated field was programmed");

  rx_no_write_a: assert property (
    IS_RX && wr_access && sel_reg != REG_LANE_IDENTIFIER && !cap_valid[0] |=>
      $stable(lane_raw[0]))
    else $error("receiver parameters changed by software");

  // Writes of alignment parameters, used by the store checks below.
  sequence cfg_write_s;
    wr_access && sel_reg != REG_LANE_IDENTIFIER;
  endsequence

  // A lane identifier write stays private to its own lane.
  lane_identifier_private_a: assert property (
    NUM_LANES > 1 && wr_access && sel_reg == REG_LANE_IDENTIFIER &&
      sel_lane == 6'h00 |=> $stable(lane_identifier[NUM_LANES-1]))
    else $error("lane identifier write reached another lane");

  // The last lane's transmit lane number follows its identifier.
  tx_lane_number_a: assert property (
    1'b1 |=> tx_lane_number[NUM_LANES*5-1 -: 5] ==
      $past(lane_identifier[NUM_LANES-1]))
    else $error("transmit lane number does not follow identifier");

  // The cfg3, cfg6 and cfg7 transmit outputs mirror lane 0's stored words.
  tx_cfg_mirror_a: assert property (
    1'b1 |=> tx_cfg3_word == $past(lane_raw[0][127:96]) &&
      tx_cfg6_word == $past(lane_raw[0][223:192]) &&
      tx_cfg7_word == $past(lane_raw[0][255:224]))
    else $error("transmit parameter output mismatch");

  // A software write lands in the programmable bits: of the last lane's copy for cfg3, of lane 0's for cfg6 and cfg7.
  tx_store_cfg3_a: assert property (
    cfg_write_s ##0 (!IS_RX && sel_reg == REG_CFG3) |=>
      lane_raw[NUM_LANES-1][127:96] == ($past(pwdata) & `TXW_CFG3))
    else $error("bank and device numbers not stored");

  tx_store_cfg6_a: assert property (
    cfg_write_s ##0 (!IS_RX && sel_reg == REG_CFG6) |=>
      lane_raw[0][223:192] == ($past(pwdata) & `TXW_CFG6))
    else $error("spare bytes not stored");

  tx_store_cfg7_a: assert property (
    cfg_write_s ##0 (!IS_RX && sel_reg == REG_CFG7) |=>
      lane_raw[0][255:224] == ($past(pwdata) & `TXW_CFG7))
    else $error("phase adjust fields not stored");

  // The receiver keeps the masked words of the received sequence.
  rx_capture_cfg3_a: assert property (
    IS_RX && cap_valid[0] |=>
      lane_raw[0][127:96] == ($past(cap_words[127:96]) & `MASK_CFG3))
    else $error("lane count and identifiers not captured");

  rx_capture_cfg7_a: assert property (
    IS_RX && cap_valid[0] |=>
      lane_raw[0][255:224] == ($past(cap_words[255:224]) & `MASK_CFG7))
    else $error("phase adjust fields not captured");

  // A capture on one lane leaves the other lanes' copies alone.
  rx_capture_private_a: assert property (
    IS_RX && NUM_LANES > 1 && cap_valid[0] &&
      !cap_valid[NUM_LANES-1] |=> $stable(lane_raw[NUM_LANES-1]))
    else $error("capture reached another lane");

  // A transmitter ignores the capture strobe.
  tx_no_capture_a: assert property (
    !IS_RX && cap_valid[0] && !wr_access |=> $stable(lane_raw[0]))
    else $error("transmitter took a received sequence");

  // Generated transmit fields read back as the build inputs.
  tx_build_view_a: assert property (
    !IS_RX |-> view[0][REG_CFG2] == word_t'(build_frames_m1) &&
      view[0][REG_CFG0][2:0] == build_subclass)
    else $error("generated frame fields not shown");

  tx_scramble_view_a: assert property (
    !IS_RX |-> view[0][REG_CFG5][0] == build_scrambling_enable)
    else $error("scrambling enable not shown");

  tx_checksum_view_a: assert property (
    !IS_RX |-> view[NUM_LANES-1][REG_CFG6][23:16] ==
      tx_lane_checksum[NUM_LANES*8-1 -: 8])
    else $error("lane checksum not shown");

  // A transmitter read returns the generated octet count.
  tx_octets_read_a: assert property (
    read_setup_s ##0 (!IS_RX && sel_reg == REG_CFG1) |=>
      read_access_s |-> prdata == word_t'($past(build_octets_m1)))
    else $error("octets per frame read back wrong");

  // Mapped accesses complete at once without an error.
  mapped_access_a: assert property (
    access_phase && hit |-> pready && !pslverr)
    else $error("mapped access stalled or errored");

endmodule
`default_nettype wire

//--- src/lane_align_pkg.sv
// Types and the field mask lookup shared by the lane alignment bank.
`include "lane_align_regs.svh"
`default_nettype none
package lane_align_pkg;

  typedef logic [31:0] word_t;

  // Register index inside one lane's window.
  typedef enum logic [3:0] {
    REG_LANE_IDENTIFIER = 4'h0,
    REG_CFG0    = 4'h1,
    REG_CFG1    = 4'h2,
    REG_CFG2    = 4'h3,
    REG_CFG3    = 4'h4,
    REG_CFG4    = 4'h5,
    REG_CFG5    = 4'h6,
    REG_CFG6    = 4'h7,
    REG_CFG7    = 4'h8
  } reg_index_t;

  // Implemented bits of a register; everything else reads as zero.
  function automatic word_t field_mask(input logic [3:0] idx);
    word_t m;
    m = 32'h0000_0000;
    if (idx == REG_LANE_IDENTIFIER) m = `MASK_LANE_IDENTIFIER;
    else if (idx == REG_CFG0) m = `MASK_CFG0;
    else if (idx == REG_CFG1) m = `MASK_CFG1;
    else if (idx == REG_CFG2) m = `MASK_CFG2;
    else if (idx == REG_CFG3) m = `MASK_CFG3;
    else if (idx == REG_CFG4) m = `MASK_CFG4;
    else if (idx == REG_CFG5) m = `MASK_CFG5;
    else if (idx == REG_CFG6) m = `MASK_CFG6;
    else if (idx == REG_CFG7) m = `MASK_CFG7;
    return m;
  endfunction

  // Bits a transmitter lets software program.
  function automatic word_t tx_write_mask(input logic [3:0] idx);
    word_t m;
    m = 32'h0000_0000;
    if (idx == REG_LANE_IDENTIFIER) m = `MASK_LANE_IDENTIFIER;
    else if (idx == REG_CFG3) m = `TXW_CFG3;
    else if (idx == REG_CFG4) m = `TXW_CFG4;
    else if (idx == REG_CFG5) m = `TXW_CFG5;
    else if (idx == REG_CFG6) m = `TXW_CFG6;
    else if (idx == REG_CFG7) m = `TXW_CFG7;
    return m;
  endfunction

endpackage
`default_nettype wire

//--- src/lane_align_regs.svh
// Offsets, field positions, masks and reset values of the lane alignment bank.
`ifndef LANE_ALIGN_REGS_SVH
`define LANE_ALIGN_REGS_SVH

// ----------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------
`define LANE_STRIDE        12'h040
`define LANE_SEL_MSB       11
`define LANE_SEL_LSB       6
`define REG_SEL_MSB        5
`define REG_SEL_LSB        2
`define REG_COUNT          9
`define OFF_LANE_IDENTIFIER        12'h000
`define OFF_CFG0           12'h004
`define OFF_CFG1           12'h008
`define OFF_CFG2           12'h00c
`define OFF_CFG3           12'h010
`define OFF_CFG4           12'h014
`define OFF_CFG5           12'h018
`define OFF_CFG6           12'h01c
`define OFF_CFG7           12'h020

// ----------------------------------------------------------------------
// Implemented bits of each register, in receive form
// ----------------------------------------------------------------------
`define MASK_LANE_IDENTIFIER       32'h0000_001f
`define MASK_CFG0          32'h0000_0707
`define MASK_CFG1          32'h0000_00ff
`define MASK_CFG2          32'h0000_001f
`define MASK_CFG3          32'h1f1f_0fff
`define MASK_CFG4          32'h031f_1fff
`define MASK_CFG5          32'h1f01_1f01
`define MASK_CFG6          32'h00ff_ffff
`define MASK_CFG7          32'h0001_010f

// ----------------------------------------------------------------------
// Bits that software may program in a transmitter
// ----------------------------------------------------------------------
`define TXW_CFG3           32'h0000_0fff
`define TXW_CFG4           32'h031f_1fff
`define TXW_CFG5           32'h1f01_1f00
`define TXW_CFG6           32'h0000_ffff
`define TXW_CFG7           32'h0001_010f

// ----------------------------------------------------------------------
// Fields generated by the core in a transmitter
// ----------------------------------------------------------------------
`define REVISION_LSB       8
`define LANES_LSB          24
`define LANE_NUMBER_LSB    16
`define CHECKSUM_LSB       16
`define CFG_RESET          32'h0000_0000

`endif

//--- src/lane_cfg_bank.sv
// One lane's identifier and alignment parameter registers.
`include "lane_align_regs.svh"
`default_nettype none
module lane_cfg_bank #(
  parameter int LANE_INDEX = 0,
  parameter bit IS_RX      = 1'b1
) (
  // Clock and reset.
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Register write port.
  input  wire logic         wr_en,
  input  wire logic [3:0]   wr_index,
  input  wire logic [31:0]  wr_data,
  // Parameters captured from the received alignment sequence.
  input  wire logic         cap_valid,
  input  wire logic [255:0] cap_words,
  // Stored contents.
  output logic [4:0]        lane_identifier,
  output logic [255:0]      cfg_words
);
  import lane_align_pkg::*;

  logic [31:0] cfg_store [8];
  logic [31:0] wmask;

  // The writable bits of the addressed register.
  assign wmask = tx_write_mask(wr_index) & wr_data;

  // Lane identifier resets to the lane's own index and takes any 0..31.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_identifier <= 5'(LANE_INDEX);
    end else if (wr_en && wr_index == REG_LANE_IDENTIFIER) begin
      lane_identifier <= wr_data[4:0];
    end
  end

  // A receiver loads every field from the sequence; a transmitter takes
  // software writes on its programmable fields only.
  generate
    for (genvar i = 0; i < 8; i++) begin : g_cfg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg_store[i] <= `CFG_RESET;
        end else if (IS_RX && cap_valid) begin
          cfg_store[i] <= cap_words[i*32 +: 32] &
                          field_mask(4'(i + 1));
        end else if (!IS_RX && wr_en && wr_index == 4'(i + 1)) begin
          cfg_store[i] <= wmask;
        end
      end
      assign cfg_words[i*32 +: 32] = cfg_store[i];
    end
  endgenerate

endmodule
`default_nettype wire
